/* File: rtl/pd_hold_map.svh */
// constants for the pin-controlled power-down hold logic
`ifndef PD_HOLD_MAP_SVH
`define PD_HOLD_MAP_SVH

// user pins under power-down control
`define PD_IO_W        8
// core clock period in ns
`define PD_CLK_NS      10
// wake time after the sleep pin falls, in ns
`define PD_WAKE_NS     1000
// edges from a sleep pin change to the state change
`define PD_ENTRY_LAT   5
// wake count net of pin latency, so the whole exit fits the wake time
`define PD_WAKE_CYC    ((`PD_WAKE_NS / `PD_CLK_NS) - `PD_ENTRY_LAT)
`define PD_CNT_W       7
`define PD_CNT_ZERO    7'h00
`define PD_CNT_ONE     7'h01
// synchroniser depth for pin inputs
`define PD_SYNC_D      3
// reset values
`define PD_IO_ZERO     8'h00
`define PD_BIT_ZERO    1'h0

`endif

/* File: rtl/pd_hold_pkg.sv */
// types of the pin-controlled power-down hold logic
`include "pd_hold_map.svh"

package pd_hold_pkg;

	typedef enum logic [1:0] {
		ST_RUN   = 2'h0,
		ST_SLEEP = 2'h1,
		ST_WAKE  = 2'h2
	} pd_state_t;

	typedef logic [`PD_IO_W-1:0]  io_vec_t;
	typedef logic [`PD_CNT_W-1:0] wake_cnt_t;

endpackage : pd_hold_pkg

/* File: rtl/pd_hold_if.sv */
// link between the power-down controller and its input hold bank
`timescale 1ns/1ps
`include "pd_hold_map.svh"

interface pd_hold_if;
	logic                 freeze;
	pd_hold_pkg::io_vec_t oeHeld;
	pd_hold_pkg::io_vec_t inLevel;
	pd_hold_pkg::io_vec_t keepEn;

	modport ctrl (
		output freeze,
		output oeHeld,
		input  inLevel,
		input  keepEn
	);

	modport bank (
		input  freeze,
		input  oeHeld,
		output inLevel,
		output keepEn
	);
endinterface : pd_hold_if

/* File: rtl/pin_hold_bank.sv */
// per-pin input synchroniser, input blocking and hold latch
`timescale 1ns/1ps
`include "pd_hold_map.svh"

module pin_hold_bank (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	// raw pin levels
	input  wire pd_hold_pkg::io_vec_t padIn,
	// controller side
	pd_hold_if.bank                   hold
);

	genvar i;
	generate
		for (i = 0; i < `PD_IO_W; i++) begin : g_pin
			logic [`PD_SYNC_D-1:0] sync_r;
			logic [`PD_SYNC_D-1:0] sync_nxt;
			logic                  level_r;
			logic                  level_nxt;

			always_comb begin
				sync_nxt = {sync_r[`PD_SYNC_D-2:0], padIn[i]};
				level_nxt = level_r;
				// a change counts once stages two and three agree
				if (!hold.freeze && (sync_r[1] == sync_r[2])) begin // R05
					level_nxt = sync_r[2];
				end
			end

			always_ff @(posedge core_clk or posedge reset) begin
				if (reset) begin
					sync_r  <= '0;
					level_r <= `PD_BIT_ZERO;
				end else begin
					sync_r  <= sync_nxt;
					level_r <= level_nxt;
				end
			end

			assign hold.inLevel[i] = level_r;
			// keeper only where no output drives the pin
			assign hold.keepEn[i] = hold.freeze & ~hold.oeHeld[i]; // R06
		end
	endgenerate

endmodule : pin_hold_bank

/* File: rtl/pin_power_down_hold.sv */
// pin-controlled power-down controller with output and state hold
`timescale 1ns/1ps
`include "pd_hold_map.svh"

// How it works
// (R01) enabled sleep pin acts as power-down control, not ordinary input
// (R02) power down while an enabled first or second sleep pin is high
// (R03) freeze outputs and core state on entry; outputs stay valid
// (R04) outputs that were high impedance at entry stay high impedance
// (R05) all inputs except the sleep pin are blocked while powered down
// (R06) hold latches keep undriven pins at their last level
// (R07) power-down exists only when configured; otherwise pin is normal
// (R08) a configured sleep pin never reaches the logic array
// (R09) board holds inputs, enables, clocks valid 7 ns before sleep
// (R10) board holds inputs, enables, clocks 12 ns after sleep rises
// (R11) board waits 1 us after sleep falls before inputs count
// (R12) valid output data within 1 us after sleep pin falls
// (R13) wake resumes from held state, no reset, nothing lost

module pin_power_down_hold (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	// configuration
	input  wire logic                 firstSleepEnable,
	input  wire logic                 secondSleepEnable,
	// sleep pins
	input  wire logic                 first_sleep_pin,
	input  wire logic                 second_sleep_pin,
	// user pins
	input  wire pd_hold_pkg::io_vec_t padIn,
	output pd_hold_pkg::io_vec_t      padOut,
	output pd_hold_pkg::io_vec_t      padOe,
	output pd_hold_pkg::io_vec_t      keepOut,
	output pd_hold_pkg::io_vec_t      keepOe,
	// logic array side
	input  wire pd_hold_pkg::io_vec_t coreOut,
	input  wire pd_hold_pkg::io_vec_t coreOe,
	output pd_hold_pkg::io_vec_t      coreIn,
	output logic                      coreFreeze,
	output logic                      arrayFirstPin,
	output logic                      arraySecondPin,
	// status
	output logic                      poweredDown,
	output logic                      wakeDone
);

	pd_hold_if hold ();

	pin_hold_bank u_bank (
		.core_clk (core_clk),
		.reset    (reset),
		.padIn    (padIn),
		.hold     (hold.bank)
	);

	// sleep pin synchronisers and filtered levels
	logic [`PD_SYNC_D-1:0] firstSync_r;
	logic [`PD_SYNC_D-1:0] firstSync_nxt;
	logic [`PD_SYNC_D-1:0] secondSync_r;
	logic [`PD_SYNC_D-1:0] secondSync_nxt;
	logic                  firstLevel_r;
	logic                  firstLevel_nxt;
	logic                  secondLevel_r;
	logic                  secondLevel_nxt;

	always_comb begin
		firstSync_nxt   = {firstSync_r[`PD_SYNC_D-2:0], first_sleep_pin};
		secondSync_nxt  = {secondSync_r[`PD_SYNC_D-2:0], second_sleep_pin};
		firstLevel_nxt  = firstLevel_r;
		secondLevel_nxt = secondLevel_r;
		// sleep pins are never blocked, even while powered down
		if (firstSync_r[1] == firstSync_r[2]) begin
			firstLevel_nxt = firstSync_r[2];
		end
		if (secondSync_r[1] == secondSync_r[2]) begin
			secondLevel_nxt = secondSync_r[2];
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			firstSync_r   <= '0;
			secondSync_r  <= '0;
			firstLevel_r  <= `PD_BIT_ZERO;
			secondLevel_r <= `PD_BIT_ZERO;
		end else begin
			firstSync_r   <= firstSync_nxt;
			secondSync_r  <= secondSync_nxt;
			firstLevel_r  <= firstLevel_nxt;
			secondLevel_r <= secondLevel_nxt;
		end
	end

	// request to sleep from whichever pins are configured
	logic sleepReq;
	assign sleepReq = (firstSleepEnable & firstLevel_r) // R01 R07
		| (secondSleepEnable & secondLevel_r); // R02

	// unconfigured sleep pins behave as ordinary inputs
	logic arrayFirst_r;
	logic arrayFirst_nxt;
	logic arraySecond_r;
	logic arraySecond_nxt;

	always_comb begin
		arrayFirst_nxt  = arrayFirst_r;
		arraySecond_nxt = arraySecond_r;
		if (firstSleepEnable) begin
			arrayFirst_nxt = `PD_BIT_ZERO; // R08
		end else if (!hold.freeze) begin
			arrayFirst_nxt = firstLevel_r; // R07
		end
		if (secondSleepEnable) begin
			arraySecond_nxt = `PD_BIT_ZERO; // R08
		end else if (!hold.freeze) begin
			arraySecond_nxt = secondLevel_r; // R05 R07
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			arrayFirst_r  <= `PD_BIT_ZERO;
			arraySecond_r <= `PD_BIT_ZERO;
		end else begin
			arrayFirst_r  <= arrayFirst_nxt;
			arraySecond_r <= arraySecond_nxt;
		end
	end

	// power-down sequencing
	pd_hold_pkg::pd_state_t state_r;
	pd_hold_pkg::pd_state_t state_nxt;
	pd_hold_pkg::wake_cnt_t wakeCnt_r;
	pd_hold_pkg::wake_cnt_t wakeCnt_nxt;

	always_comb begin
		state_nxt   = state_r;
		wakeCnt_nxt = wakeCnt_r;
		case (state_r)
			pd_hold_pkg::ST_RUN: begin
				// sleep pin and inputs share one latency, so the
				// frozen inputs are sampled one to two edges after the sleep edge
				if (sleepReq) begin // R02 R09 R10
					state_nxt = pd_hold_pkg::ST_SLEEP;
				end
			end
			pd_hold_pkg::ST_SLEEP: begin
				if (!sleepReq) begin
					state_nxt   = pd_hold_pkg::ST_WAKE;
					wakeCnt_nxt = pd_hold_pkg::wake_cnt_t'(`PD_WAKE_CYC);
				end
			end
			pd_hold_pkg::ST_WAKE: begin
				// the sleep pin may rise again before the wake ends
				if (sleepReq) begin
					state_nxt   = pd_hold_pkg::ST_SLEEP;
					wakeCnt_nxt = `PD_CNT_ZERO;
				end else if (wakeCnt_r == `PD_CNT_ONE) begin // R11 R12
					state_nxt   = pd_hold_pkg::ST_RUN; // R13
					wakeCnt_nxt = `PD_CNT_ZERO;
				end else begin
					wakeCnt_nxt = wakeCnt_r - `PD_CNT_ONE;
				end
			end
			default: begin
				state_nxt   = pd_hold_pkg::ST_RUN;
				wakeCnt_nxt = `PD_CNT_ZERO;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_r   <= pd_hold_pkg::ST_RUN;
			wakeCnt_r <= `PD_CNT_ZERO;
		end else begin
			state_r   <= state_nxt;
			wakeCnt_r <= wakeCnt_nxt;
		end
	end

	// freeze covers sleep and the whole wake time
	assign hold.freeze = (state_r != pd_hold_pkg::ST_RUN); // R03 R05

	// output data and enables, held while frozen
	pd_hold_pkg::io_vec_t padOut_r;
	pd_hold_pkg::io_vec_t padOut_nxt;
	pd_hold_pkg::io_vec_t padOe_r;
	pd_hold_pkg::io_vec_t padOe_nxt;
	pd_hold_pkg::io_vec_t coreIn_r;
	pd_hold_pkg::io_vec_t coreIn_nxt;

	always_comb begin
		padOut_nxt = padOut_r;
		padOe_nxt  = padOe_r;
		coreIn_nxt = coreIn_r;
		if (!hold.freeze) begin
			padOut_nxt = coreOut;
			padOe_nxt  = coreOe;
			coreIn_nxt = hold.inLevel;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			padOut_r <= `PD_IO_ZERO;
			padOe_r  <= `PD_IO_ZERO;
			coreIn_r <= `PD_IO_ZERO;
		end else begin
			padOut_r <= padOut_nxt; // R03 R12
			padOe_r  <= padOe_nxt; // R04
			coreIn_r <= coreIn_nxt; // R05 R13
		end
	end

	assign hold.oeHeld = padOe_r;

	// keeper is weak; it never overrides a driven output
	pd_hold_pkg::io_vec_t keepOut_r;
	pd_hold_pkg::io_vec_t keepOut_nxt;
	pd_hold_pkg::io_vec_t keepOe_r;
	pd_hold_pkg::io_vec_t keepOe_nxt;

	always_comb begin
		keepOut_nxt = hold.inLevel; // R06
		keepOe_nxt  = hold.keepEn; // R06
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			keepOut_r <= `PD_IO_ZERO;
			keepOe_r  <= `PD_IO_ZERO;
		end else begin
			keepOut_r <= keepOut_nxt;
			keepOe_r  <= keepOe_nxt;
		end
	end

	assign padOut         = padOut_r;
	assign padOe          = padOe_r;
	assign keepOut        = keepOut_r;
	assign keepOe         = keepOe_r;
	assign coreIn         = coreIn_r;
	// core registers hold rather than reset, so wake loses nothing
	assign coreFreeze     = hold.freeze; // R03 R13
	assign arrayFirstPin  = arrayFirst_r;
	assign arraySecondPin = arraySecond_r;
	assign poweredDown    = (state_r == pd_hold_pkg::ST_SLEEP);
	assign wakeDone       = (state_r == pd_hold_pkg::ST_RUN);

endmodule : pin_power_down_hold

/* File: tb/pin_power_down_hold_props.sv */
// assertion checker for the power-down hold block
`timescale 1ns/1ps
`include "pd_hold_map.svh"

module pin_power_down_hold_props (
	// clock and reset
	input wire logic                 core_clk,
	input wire logic                 reset,
	// configuration and sleep pin
	input wire logic                 firstSleepEnable,
	input wire logic                 secondSleepEnable,
	input wire logic                 first_sleep_pin,
	// data paths
	input wire pd_hold_pkg::io_vec_t coreOut,
	input wire pd_hold_pkg::io_vec_t coreOe,
	input wire pd_hold_pkg::io_vec_t padOut,
	input wire pd_hold_pkg::io_vec_t padOe,
	input wire pd_hold_pkg::io_vec_t coreIn,
	input wire pd_hold_pkg::io_vec_t keepOut,
	input wire pd_hold_pkg::io_vec_t keepOe,
	// status
	input wire logic                 coreFreeze,
	input wire logic                 arrayFirstPin,
	input wire logic                 poweredDown,
	input wire logic                 wakeDone
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	a_sleep_entry: assert property (
		(firstSleepEnable && first_sleep_pin)[*8] |-> poweredDown)
		else $error("sleep pin held high but not asleep");
	a_unconfig_awake: assert property (
		(!firstSleepEnable && !secondSleepEnable)[*3] |-> !poweredDown)
		else $error("asleep with no sleep pin configured");
	a_array_masked: assert property (
		(firstSleepEnable && !coreFreeze)[*8] |-> !arrayFirstPin)
		else $error("configured sleep pin reaches the array");
	a_out_held: assert property (
		coreFreeze |=> $stable(padOut) && $stable(padOe))
		else $error("pad outputs moved while frozen");
	a_in_blocked: assert property (
		coreFreeze |=> $stable(coreIn) && $stable(keepOut))
		else $error("inputs passed while frozen");
	a_keeper_on: assert property (
		poweredDown && $past(poweredDown) |-> keepOe == ~padOe)
		else $error("keeper enable wrong while asleep");
	a_run_path: assert property (
		wakeDone && $past(wakeDone) && !$past(reset)
		|-> padOut == $past(coreOut) && padOe == $past(coreOe))
		else $error("pads do not follow the array in run");
	a_wake_bound: assert property (
		$fell(poweredDown) |-> ##[1:95] (wakeDone || poweredDown))
		else $error("wake took too long");

	c_sleep: cover property ($rose(poweredDown));
	c_wake: cover property ($rose(wakeDone));
	c_keep: cover property (keepOe != 8'h00);
endmodule : pin_power_down_hold_props

bind pin_power_down_hold pin_power_down_hold_props u_props (
	.core_clk, .reset, .firstSleepEnable, .secondSleepEnable,
	.first_sleep_pin, .coreOut, .coreOe, .padOut, .padOe, .coreIn,
	.keepOut, .keepOe, .coreFreeze, .arrayFirstPin, .poweredDown,
	.wakeDone
);

/* File: tb/board_model.sv */
// board-side driver of the sleep pins and user pad levels
`timescale 1ns/1ps
`include "pd_hold_map.svh"

module board_model (
	// clock
	input wire logic                 core_clk,
	// requests from the bench
	input wire logic [1:0]           sleepCmd,
	input wire pd_hold_pkg::io_vec_t padWant,
	// board pins
	output logic [1:0]               sleepPin,
	output pd_hold_pkg::io_vec_t     padDrive
);
	logic [1:0] guard;

	initial begin
		sleepPin = 2'h0;
		padDrive = 8'h00;
		guard = 2'h0;
	end

	// pads never move within three cycles after a pin edge
	always @(posedge core_clk) begin
		if (guard != 2'h0) begin
			guard <= guard - 2'h1;
		end else if (sleepCmd != sleepPin) begin
			sleepPin <= sleepCmd;
			guard <= 2'h3;
		end else begin
			padDrive <= padWant;
		end
	end
endmodule : board_model

/* File: tb/pin_power_down_hold_test.sv */
// self-checking bench for the power-down hold block
`timescale 1ns/1ps
`include "pd_hold_map.svh"

module pin_power_down_hold_test;
	logic                 core_clk = 1'h0;
	logic                 reset = 1'h1;
	logic                 firstSleepEnable = 1'h0;
	logic                 secondSleepEnable = 1'h0;
	logic [1:0]           sleepCmd = 2'h0;
	logic [1:0]           sleepPin;
	pd_hold_pkg::io_vec_t padWant = 8'h00;
	pd_hold_pkg::io_vec_t coreOut = 8'h00;
	pd_hold_pkg::io_vec_t coreOe = 8'h00;
	pd_hold_pkg::io_vec_t padDrive, padOut, padOe, keepOut, keepOe, coreIn;
	logic                 coreFreeze, arrayFirstPin, arraySecondPin;
	logic                 poweredDown, wakeDone;
	int                   fail_count = 0;
	int                   total_checks = 0;

	always #5 core_clk = ~core_clk;

	board_model u_board (.core_clk, .sleepCmd, .padWant, .sleepPin,
		.padDrive);
	pin_power_down_hold uut (.core_clk, .reset, .firstSleepEnable,
		.secondSleepEnable, .first_sleep_pin(sleepPin[0]),
		.second_sleep_pin(sleepPin[1]), .padIn(padDrive), .padOut,
		.padOe, .keepOut, .keepOe, .coreOut, .coreOe, .coreIn,
		.coreFreeze, .arrayFirstPin, .arraySecondPin, .poweredDown,
		.wakeDone);

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task automatic chk_vec(input pd_hold_pkg::io_vec_t got, exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_vec

	task automatic chk_bit(input logic got, exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	task automatic t_reset;
		chk_vec(padOut, 8'h00);
		chk_vec(keepOe, 8'h00);
		chk_bit(coreFreeze, 1'h0);
		chk_bit(wakeDone, 1'h1);
		chk_bit(poweredDown, 1'h0);
		$display("reset test done");
	endtask : t_reset

	// pin 0 unconfigured: it must stay an ordinary array input
	task automatic t_plain_pin;
		coreOut <= 8'ha5;
		coreOe <= 8'h0f;
		padWant <= 8'h3c;
		secondSleepEnable <= 1'h1;
		sleepCmd <= 2'h1;
		cyc(12);
		chk_vec(padOut, 8'ha5);
		chk_vec(padOe, 8'h0f);
		chk_vec(coreIn, 8'h3c);
		chk_vec(keepOe, 8'h00);
		chk_bit(poweredDown, 1'h0);
		chk_bit(arrayFirstPin, 1'h1);
		chk_bit(arraySecondPin, 1'h0);
		sleepCmd <= 2'h0;
		cyc(8);
		chk_bit(arrayFirstPin, 1'h0);
		// neither pin configured: both high must not power down
		secondSleepEnable <= 1'h0;
		sleepCmd <= 2'h3;
		cyc(10);
		chk_bit(poweredDown, 1'h0);
		chk_bit(arraySecondPin, 1'h1);
		sleepCmd <= 2'h0;
		cyc(8);
		$display("plain pin test done");
	endtask : t_plain_pin

	task automatic t_sleep(input int pin, input pd_hold_pkg::io_vec_t d);
		int n;
		pd_hold_pkg::io_vec_t oe;
		oe = {d[3:0], d[7:4]};
		firstSleepEnable <= (pin == 0);
		secondSleepEnable <= (pin == 1);
		coreOut <= d;
		coreOe <= oe;
		padWant <= ~d;
		cyc(12);
		sleepCmd <= (pin == 0) ? 2'h1 : 2'h2;
		n = 0;
		while (poweredDown !== 1'h1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk_bit(poweredDown, 1'h1);
		coreOut <= ~d;
		coreOe <= ~oe;
		padWant <= d;
		cyc(20);
		chk_vec(padOut, d);
		chk_vec(padOe, oe);
		chk_vec(coreIn, ~d);
		chk_vec(keepOut, ~d);
		chk_vec(keepOe, ~oe);
		chk_bit(coreFreeze, 1'h1);
		chk_bit(pin == 0 ? arrayFirstPin : arraySecondPin, 1'h0);
		sleepCmd <= 2'h0;
		n = 0;
		// nothing is relied on before the device reports it is awake
		while (wakeDone !== 1'h1 && n < 200) begin
			cyc(1);
			n++;
		end
		// pin falls one edge after the command; 1 us is 100 cycles,
		// and the run state shows one edge after it is entered
		chk_bit(n >= 95 && n <= 102, 1'h1);
		cyc(4);
		chk_vec(padOut, ~d);
		chk_vec(padOe, ~oe);
		chk_vec(coreIn, d);
		chk_vec(keepOe, 8'h00);
		chk_bit(coreFreeze, 1'h0);
		$display("sleep test on pin %0d done", pin);
	endtask : t_sleep

	initial begin
		cyc(2000);
		fail_count++;
		tally_and_finish();
	end

	initial begin
		cyc(10);
		t_reset();
		reset <= 1'b0;
		t_plain_pin();
		t_sleep(0, 8'h96);
		t_sleep(1, 8'h4b);
		tally_and_finish();
	end
endmodule : pin_power_down_hold_test
